/* include/ecu_pkg.sv */
// Shared constants, register map and carrier types for the event-condition unit.
// Assumes a single core clock domain and a plain address/strobe register port.
package ecu_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NUM_CH     = 12;
   localparam int ADDR_W     = 32;
   localparam int DATA_W     = 32;
   localparam int ADDRESS_SPACE_IDENTIFIER_W     = 8;
   localparam int CNT_W      = 16;
   localparam int REG_ADDR_W = 8;

   // ****************************************************************
   // Register map: each channel owns a block of eight words
   // ****************************************************************
   localparam logic [REG_ADDR_W-1:0] CH_STRIDE    = 8'h08;
   localparam logic [2:0]            R_CTRL       = 3'h0;
   localparam logic [2:0]            R_ADDR       = 3'h1;
   localparam logic [2:0]            R_ADDR_HI    = 3'h2;
   localparam logic [2:0]            R_DATA       = 3'h3;
   localparam logic [2:0]            R_ADDRESS_SPACE_IDENTIFIER       = 3'h4;
   localparam logic [2:0]            R_COUNT      = 3'h5;
   localparam logic [2:0]            R_STAT       = 3'h6;
   localparam logic [REG_ADDR_W-1:0] GLOBAL_BASE  = 8'h60;
   localparam logic [REG_ADDR_W-1:0] R_SWTRACE    = 8'h60;
   localparam logic [REG_ADDR_W-1:0] R_SEQ        = 8'h61;
   localparam logic [REG_ADDR_W-1:0] R_HITS       = 8'h62;

   // Control field positions
   localparam int C_EN_ADDR   = 0;
   localparam int C_EN_DATA   = 1;
   localparam int C_EN_ADDRESS_SPACE_IDENTIFIER   = 2;
   localparam int C_EN_BUS    = 3;
   localparam int C_EN_WIN    = 4;
   localparam int C_EN_SYS    = 5;
   localparam int C_EN_TLB    = 6;
   localparam int C_EN_CNT    = 7;
   localparam int C_EN_BR     = 8;
   localparam int C_ACT_BRK   = 9;
   localparam int C_ACT_TRC   = 10;
   localparam int C_ACT_PST   = 11;
   localparam int C_ACT_PSP   = 12;
   localparam int C_SIZE_LO   = 13;
   localparam int C_RW_DIR    = 15;
   localparam int C_RW_EN     = 16;
   localparam int C_BUS_Y     = 17;
   localparam int CTRL_W      = 18;

   // Data compare sizes
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;

   // Branch channel: trace capture on after reset
   localparam logic [CTRL_W-1:0] CTRL_RST     = 18'h00000;
   localparam logic [CTRL_W-1:0] CTRL_RST_BR  = 18'h00500;

   // Per-channel capability masks of allowed control bits (entry 0 = channel 1)
   localparam logic [CTRL_W-1:0] CAP [NUM_CH] = '{
      18'h3FA0D, 18'h3FA8F, 18'h3BA05, 18'h3BA05, 18'h3FE1C, 18'h3FE1C,
      18'h00240, 18'h3FE21, 18'h3FE21, 18'h3FA0D, 18'h3FA8F, 18'h3FF00};

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic              valid;
      logic              write;
      logic [1:0]        size;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] pc;
      logic [DATA_W-1:0] data;
      logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier;
      logic              xy_valid;
      logic              y_sel;
      logic [ADDR_W-1:0] xy_addr;
      logic              tlb_load_instruction;
      logic              branch;
   } cpu_obs_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } sys_obs_t;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [ADDR_W-1:0] addr;
      logic [ADDR_W-1:0] addr_hi;
      logic [DATA_W-1:0] data;
      logic [ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier;
   } ch_cfg_t;

endpackage : ecu_pkg

/* core/ecu_match.sv */
// One event-condition channel comparator, purely combinational.
// Assumes configuration is already masked to the channel's capabilities.
`timescale 1ns/1ns
module ecu_match
   import ecu_pkg::*;
(
   input  wire ch_cfg_t  cfg,
   input  wire cpu_obs_t cpu,
   input  wire sys_obs_t sys,
   output logic          hit
);
   logic [DATA_W-1:0] dmask;
   logic              m_addr, m_data, m_address_space_identifier, m_bus, m_win, m_sys, m_tlb, m_br, m_rw, any_en;

   // Data compare width
   always_comb begin
      unique case (cfg.ctrl[C_SIZE_LO +: 2])
         SIZE_BYTE: dmask = 32'h000000FF;
         SIZE_WORD: dmask = 32'h0000FFFF;
         default:   dmask = 32'hFFFFFFFF;
      endcase
   end

   assign m_addr = cpu.valid && (cpu.addr == cfg.addr || cpu.pc == cfg.addr);
   assign m_data = cpu.valid && ((cpu.data & dmask) == (cfg.data & dmask));
   assign m_address_space_identifier = cpu.valid && (cpu.address_space_identifier == cfg.address_space_identifier);
   // Bus state: data bus or selected X/Y address bus
   assign m_rw   = !cfg.ctrl[C_RW_EN] || (cpu.write == cfg.ctrl[C_RW_DIR]);
   assign m_bus  = m_rw && ((cpu.valid && cpu.data == cfg.data) ||
                   (cpu.xy_valid && cpu.y_sel == cfg.ctrl[C_BUS_Y]
                    && cpu.xy_addr == cfg.addr));
   assign m_win  = (cpu.valid && cpu.addr >= cfg.addr && cpu.addr <= cfg.addr_hi) ||
                   (cpu.xy_valid && cpu.xy_addr >= cfg.addr && cpu.xy_addr <= cfg.addr_hi);
   assign m_sys  = sys.valid && (sys.addr == cfg.addr || sys.data == cfg.data);
   assign m_tlb  = cpu.tlb_load_instruction;
   assign m_br   = cpu.branch;

   // All enabled conditions must hold for the same access
   assign any_en = |cfg.ctrl[C_EN_BR:C_EN_ADDR] & ~cfg.ctrl[C_EN_CNT];
   assign hit = any_en
      && (!cfg.ctrl[C_EN_ADDR] || m_addr)
      && (!cfg.ctrl[C_EN_DATA] || m_data)
      && (!cfg.ctrl[C_EN_ADDRESS_SPACE_IDENTIFIER] || m_address_space_identifier)
      && (!cfg.ctrl[C_EN_BUS]  || m_bus)
      && (!cfg.ctrl[C_EN_WIN]  || m_win)
      && (!cfg.ctrl[C_EN_SYS]  || m_sys)
      && (!cfg.ctrl[C_EN_TLB]  || m_tlb)
      && (!cfg.ctrl[C_EN_BR]   || m_br);

endmodule : ecu_match

/* core/event_condition_break_unit.sv */
// Twelve-channel event-condition unit with software-trace enable.
// Assumes observed core and system bus signals are on core_clk; register port is
// a single-cycle strobe master on the same clock.
//
// Notes on behaviour
// - Twelve independently configured channels plus a software-trace channel.
// - Address condition matches on CPU address bus or program counter.
// - Data condition matches CPU data bus at byte, word or longword size.
// - Bus-state condition matches data bus or X/Y bus address.
// - Bus-state read/write qualifier gates the match on access direction.
// - Window condition matches any access inside the address range.
// - System bus condition matches system bus address or data.
// - TLB-load channel breaks on each translation-buffer load instruction.
// - Count channel breaks only when the occurrence count reaches the programmed number.
// - Branch channel matches branches; trace capture is on after reset.
// - Each channel selects break, trace, performance start or stop, as far as its capability mask allows.
// - Channel 1: address, identifier, bus state; break and performance only.
// - Channels 3 and 4: address and identifier; break and performance only.
// - Channels 5 and 6: identifier, bus state, window; all actions.
// - Channel 7: TLB-load condition only, action fixed to break.
// - Software-trace channel only enables acquisition; action fixed to trace.
// - Sequential mode: channel 1 breaks only when channel 2 hit before it; channel 2 never breaks; channels 3-12 break as usual.
// - The sequential match flag is cleared whenever the program breaks.
`timescale 1ns/1ns
module event_condition_break_unit
   import ecu_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  arst_n,
   input  wire logic [REG_ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [31:0]           reg_rdata,
   input  wire cpu_obs_t              cpu,
   input  wire sys_obs_t              sys,
   output logic                       break_req,
   output logic                       trace_capture,
   output logic                       sw_trace_en,
   output logic                       perf_start,
   output logic                       perf_stop
);

   // ****************************************************************
   // Register decode
   // ****************************************************************
   logic [3:0]          sel_ch;
   logic [2:0]          sel_reg;
   logic                sel_is_ch;
   logic [NUM_CH-1:0]   wr_ch;
   assign sel_ch    = reg_addr[6:3];
   assign sel_reg   = reg_addr[2:0];
   assign sel_is_ch = (reg_addr < GLOBAL_BASE);

   ch_cfg_t           cfg      [NUM_CH];
   ch_cfg_t           cfg_eff  [NUM_CH];
   logic [CNT_W-1:0]  cnt_tgt  [NUM_CH];
   logic [CNT_W-1:0]  cnt_now  [NUM_CH];
   logic [NUM_CH-1:0] raw_hit;
   logic [NUM_CH-1:0] ch_fire;
   logic [NUM_CH-1:0] hit_seen;
   logic              seq_mode;
   logic              seq_flag;
   logic              clr_hits;

   // ****************************************************************
   // Per-channel configuration, comparator and counter
   // ****************************************************************
   generate
      for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
         logic    cnt_en;
         ch_cfg_t cfg_cmp;
         assign wr_ch[i] = reg_wr && sel_is_ch && (sel_ch == 4'(i));

         // Configuration store; unsupported control bits never stick
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               cfg[i].ctrl    <= (i == NUM_CH-1) ? CTRL_RST_BR : CTRL_RST;
               cfg[i].addr    <= '0;
               cfg[i].addr_hi <= '0;
               cfg[i].data    <= '0;
               cfg[i].address_space_identifier    <= '0;
               cnt_tgt[i]     <= '0;
            end else if (wr_ch[i]) begin
               unique case (sel_reg)
                  R_CTRL:    cfg[i].ctrl    <= reg_wdata[CTRL_W-1:0] & CAP[i];
                  R_ADDR:    cfg[i].addr    <= reg_wdata;
                  R_ADDR_HI: cfg[i].addr_hi <= reg_wdata;
                  R_DATA:    cfg[i].data    <= reg_wdata;
                  R_ADDRESS_SPACE_IDENTIFIER:    cfg[i].address_space_identifier    <= reg_wdata[ADDRESS_SPACE_IDENTIFIER_W-1:0];
                  R_COUNT:   cnt_tgt[i]     <= reg_wdata[CNT_W-1:0];
                  default:   ;
               endcase
            end
         end

         // Channel 7 action stays break; comparator never sees the count bit,
         // so one comparator serves plain and counted modes alike
         always_comb begin
            cfg_eff[i] = cfg[i];
            if (i == 6) begin
               cfg_eff[i].ctrl[C_ACT_BRK] = 1'b1;
            end
            cfg_cmp = cfg_eff[i];
            cfg_cmp.ctrl[C_EN_CNT] = 1'b0;
         end

         ecu_match u_match (
            .cfg (cfg_cmp),
            .cpu (cpu),
            .sys (sys),
            .hit (raw_hit[i])
         );

         // Occurrence counter: fires on the programmed count, then rearms
         assign cnt_en = cfg[i].ctrl[C_EN_CNT];
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               cnt_now[i] <= '0;
            end else if (wr_ch[i]) begin
               cnt_now[i] <= '0;
            end else if (cnt_en && raw_hit[i]) begin
               cnt_now[i] <= (cnt_now[i] + 16'h0001 >= cnt_tgt[i]) ? '0
                                                                   : cnt_now[i] + 16'h0001;
            end
         end
         assign ch_fire[i] = cnt_en ? (raw_hit[i] && (cnt_now[i] + 16'h0001 >= cnt_tgt[i]))
                                    : raw_hit[i];
      end
   endgenerate

   // ****************************************************************
   // Action routing
   // ****************************************************************
   logic [NUM_CH-1:0] act_brk, act_trc, act_pst, act_psp;
   logic              seq_brk;
   logic              next_break;
   generate
      for (genvar j = 0; j < NUM_CH; j++) begin : g_act
         assign act_brk[j] = ch_fire[j] && cfg_eff[j].ctrl[C_ACT_BRK];
         assign act_trc[j] = ch_fire[j] && cfg_eff[j].ctrl[C_ACT_TRC];
         assign act_pst[j] = ch_fire[j] && cfg_eff[j].ctrl[C_ACT_PST];
         assign act_psp[j] = ch_fire[j] && cfg_eff[j].ctrl[C_ACT_PSP];
      end
   endgenerate

   // Sequential mode: channel 1 breaks only after channel 2 has hit
   assign seq_brk    = act_brk[0] && seq_flag;
   assign next_break = seq_mode ? (seq_brk || (|act_brk[NUM_CH-1:2]))
                                : (|act_brk);

   // ****************************************************************
   // Sequential match flag
   // ****************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_flag <= 1'b0;
      end else if (!seq_mode || next_break) begin
         seq_flag <= 1'b0;
      end else if (ch_fire[1]) begin
         seq_flag <= 1'b1;
      end
   end

   // ****************************************************************
   // Global control: software trace and sequential mode
   // ****************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_trace_en <= 1'b0;
         seq_mode    <= 1'b0;
      end else if (reg_wr && reg_addr == R_SWTRACE) begin
         sw_trace_en <= reg_wdata[0];
      end else if (reg_wr && reg_addr == R_SEQ) begin
         seq_mode    <= reg_wdata[0];
      end
   end

   // Sticky hit record; a new hit wins over a software clear
   assign clr_hits = reg_wr && reg_addr == R_HITS;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hit_seen <= '0;
      end else begin
         hit_seen <= (clr_hits ? (hit_seen & ~reg_wdata[NUM_CH-1:0]) : hit_seen) | ch_fire;
      end
   end

   // ****************************************************************
   // Outputs, all registered
   // ****************************************************************
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         break_req     <= 1'b0;
         trace_capture <= 1'b0;
         perf_start    <= 1'b0;
         perf_stop     <= 1'b0;
      end else begin
         break_req     <= next_break;
         trace_capture <= (|act_trc) || (sw_trace_en && cpu.valid);
         perf_start    <= |act_pst;
         perf_stop     <= |act_psp;
      end
   end

   // ****************************************************************
   // Read port, data one cycle after the strobe
   // ****************************************************************
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = '0;
      if (sel_is_ch && sel_ch < 4'(NUM_CH)) begin
         unique case (sel_reg)
            R_CTRL:    next_rdata = 32'(cfg_eff[sel_ch].ctrl);
            R_ADDR:    next_rdata = cfg[sel_ch].addr;
            R_ADDR_HI: next_rdata = cfg[sel_ch].addr_hi;
            R_DATA:    next_rdata = cfg[sel_ch].data;
            R_ADDRESS_SPACE_IDENTIFIER:    next_rdata = 32'(cfg[sel_ch].address_space_identifier);
            R_COUNT:   next_rdata = 32'(cnt_tgt[sel_ch]);
            R_STAT:    next_rdata = 32'(cnt_now[sel_ch]);
            default:   next_rdata = '0;
         endcase
      end else if (reg_addr == R_SWTRACE) begin
         next_rdata = 32'(sw_trace_en);
      end else if (reg_addr == R_SEQ) begin
         next_rdata = {30'h0, seq_flag, seq_mode};
      end else if (reg_addr == R_HITS) begin
         next_rdata = 32'(hit_seen);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : '0;
      end
   end

endmodule : event_condition_break_unit

/* verification/ecu_sva.sv */
// Port checker for the event-condition unit.
// Assumes it is bound to the unit's top module and sees only its ports.
`timescale 1ns/1ns
module ecu_sva
   import ecu_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  arst_n,
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [31:0]           reg_rdata,
   input wire cpu_obs_t              cpu,
   input wire sys_obs_t              sys,
   input wire logic                  break_req,
   input wire logic                  trace_capture,
   input wire logic                  sw_trace_en,
   input wire logic                  perf_start,
   input wire logic                  perf_stop
);
   // ********************
   // Properties
   // ********************
   // One clock domain, so one clocking and one disable serve all
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (reg_rd && reg_addr > R_HITS |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (!$past(arst_n) |-> !(break_req || trace_capture
      || perf_start || perf_stop || sw_trace_en))
      else $error("output active right after reset");
   a_break_cause: assert property (break_req |-> $past(cpu.valid || sys.valid))
      else $error("break without an access");
   a_trace_cause: assert property (trace_capture |-> $past(cpu.valid || sys.valid))
      else $error("trace without an access");
   a_perf_cause: assert property (perf_start || perf_stop |-> $past(cpu.valid || sys.valid))
      else $error("perf pulse without an access");
   a_sw_follow: assert property (sw_trace_en && cpu.valid |=> trace_capture)
      else $error("software trace missed an access");
   a_sw_written: assert property ($changed(sw_trace_en) |->
      $past(reg_wr) && $past(reg_addr) == R_SWTRACE)
      else $error("software trace enable moved unwritten");
endmodule : ecu_sva

bind event_condition_break_unit ecu_sva ecu_sva_inst (.core_clk, .arst_n, .reg_addr, .reg_wr,
   .reg_rd, .reg_rdata, .cpu, .sys, .break_req, .trace_capture, .sw_trace_en, .perf_start,
   .perf_stop);

/* verification/ecu_core_model.sv */
// Behavioural core: presents one observed cpu or system bus access per call.
// Assumes calls come from one bench process at a time.
`timescale 1ns/1ns
module ecu_core_model
   import ecu_pkg::*;
(
   input  wire logic core_clk,
   output cpu_obs_t  cpu,
   output sys_obs_t  sys
);
   // ********************
   // Access driver
   // ********************
   int gap = 0; // Idle cycles before each access, for a slow core

   // Buses idle at time zero
   initial begin
      cpu = '0;
      sys = '0;
   end

   // Idle fields carry the inverse of the last access, so nothing leans on stale values
   task automatic issue(input cpu_obs_t c, input sys_obs_t s);
      cpu_obs_t ci;
      sys_obs_t si;
      ci = ~c;
      ci.valid = 1'b0;
      ci.xy_valid = 1'b0;
      ci.tlb_load_instruction = 1'b0;
      ci.branch = 1'b0;
      si = ~s;
      si.valid = 1'b0;
      repeat (gap) @(posedge core_clk);
      @(posedge core_clk);
      cpu <= c;
      sys <= s;
      @(posedge core_clk);
      cpu <= ci;
      sys <= si;
   endtask : issue
endmodule : ecu_core_model

/* verification/event_condition_break_unit_tb.sv */
// Self-checking bench for the event-condition unit.
// Assumes the core model drives cpu and sys; registers go over the strobe port.
`timescale 1ns/1ns
module event_condition_break_unit_tb;
   import ecu_pkg::*;
   // ********************
   // Signals, clock, instances
   // ********************
   logic                  core_clk  = 1'b0;
   logic                  arst_n    = 1'b0;
   logic [REG_ADDR_W-1:0] reg_addr  = '0;
   logic [31:0]           reg_wdata = '0;
   logic                  reg_wr    = 1'b0;
   logic                  reg_rd    = 1'b0;
   logic [31:0]           reg_rdata;
   cpu_obs_t              cpu;
   sys_obs_t              sys;
   logic                  break_req, trace_capture, sw_trace_en, perf_start, perf_stop;
   int                    err_count   = 0;
   int                    check_count = 0;

   // Half period of 125 MHz
   always #4 core_clk = ~core_clk;

   event_condition_break_unit event_condition_break_unit_inst (.core_clk, .arst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu, .sys, .break_req, .trace_capture,
      .sw_trace_en, .perf_start, .perf_stop);
   ecu_core_model ecu_core_model_inst (.core_clk, .cpu, .sys);

   // ********************
   // Helpers
   // ********************
   function automatic logic [31:0] bv(input int b);
      bv = 32'h1 << b;
   endfunction : bv
   function automatic logic [REG_ADDR_W-1:0] ra(input int ch, input logic [2:0] off);
      ra = REG_ADDR_W'(ch - 1) * CH_STRIDE + REG_ADDR_W'(off);
   endfunction : ra
   // Long read at addr; pc kept apart so it never matches by accident
   function automatic cpu_obs_t acc(input logic [31:0] a);
      acc = '0;
      acc.valid = 1'b1;
      acc.size = SIZE_LONG;
      acc.addr = a;
      acc.pc = a ^ 32'h8000_0000;
   endfunction : acc
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_ev(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t: brk/trc/pst/psp %b, wanted %b", $time, got, exp);
      end
   endtask : chk_ev
   task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [REG_ADDR_W-1:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rdc
   // Outputs pulse one cycle after the observed access
   task automatic ev(input cpu_obs_t c, input sys_obs_t s, input logic [3:0] e);
      ecu_core_model_inst.issue(c, s);
      #1 chk_ev({break_req, trace_capture, perf_start, perf_stop}, e);
   endtask : ev

   // ********************
   // Scenarios
   // ********************
   task automatic test_reset_caps;
      cpu_obs_t c;
      c = acc(32'h70);
      c.branch = 1'b1;
      rdc(ra(12, R_CTRL), 32'(CTRL_RST_BR));
      rdc(R_SWTRACE, 32'h0);
      ev(c, '0, 4'b0100);
      wr(8'h70, 32'hFFFF_FFFF);
      rdc(8'h70, 32'h0);
      for (int i = 1; i <= NUM_CH; i++) begin
         wr(ra(i, R_CTRL), 32'hFFFF_FFFF);
         rdc(ra(i, R_CTRL), 32'(CAP[i-1]));
         wr(ra(i, R_CTRL), 32'h0);
      end
      wr(ra(3, R_CTRL), bv(C_ACT_BRK) | bv(C_ACT_TRC) | bv(C_ACT_PST) | bv(C_ACT_PSP));
      rdc(ra(3, R_CTRL), bv(C_ACT_BRK) | bv(C_ACT_PST) | bv(C_ACT_PSP));
      $display("test reset_caps done");
   endtask : test_reset_caps

   task automatic test_addr_data;
      cpu_obs_t c;
      wr(ra(1, R_ADDR), 32'h1000);
      wr(ra(1, R_ADDRESS_SPACE_IDENTIFIER), 32'h5);
      wr(ra(1, R_CTRL), bv(C_EN_ADDR) | bv(C_ACT_BRK));
      ev(acc(32'h1000), '0, 4'b1000);
      c = acc(32'h44);
      c.pc = 32'h1000;
      ev(c, '0, 4'b1000);
      ev(acc(32'h1004), '0, 4'b0000);
      wr(ra(1, R_CTRL), bv(C_EN_ADDR) | bv(C_EN_ADDRESS_SPACE_IDENTIFIER) | bv(C_ACT_PST));
      c = acc(32'h1000);
      c.address_space_identifier = 8'h06;
      ev(c, '0, 4'b0000);
      c.address_space_identifier = 8'h05;
      ev(c, '0, 4'b0010);
      wr(ra(1, R_CTRL), 32'h0);
      wr(ra(2, R_DATA), 32'hA5C3_0F1E);
      wr(ra(2, R_CTRL), bv(C_EN_DATA) | bv(C_ACT_PSP) | (32'(SIZE_LONG) << C_SIZE_LO));
      c = acc(32'h50);
      c.data = 32'hA5C3_0F1E;
      ev(c, '0, 4'b0001);
      c.data = 32'hA5C3_0F1F;
      ev(c, '0, 4'b0000);
      wr(ra(2, R_CTRL), bv(C_EN_DATA) | bv(C_ACT_PSP) | (32'(SIZE_BYTE) << C_SIZE_LO));
      c.data = 32'h7700_001E;
      c.size = SIZE_BYTE;
      ev(c, '0, 4'b0001);
      wr(ra(2, R_CTRL), bv(C_EN_DATA) | bv(C_ACT_PSP) | (32'(SIZE_WORD) << C_SIZE_LO));
      ev(c, '0, 4'b0000);
      c.data = 32'h7700_0F1E;
      ev(c, '0, 4'b0001);
      $display("test addr_data done");
   endtask : test_addr_data

   // Slow core here, so matches arrive spread out
   task automatic test_count;
      ecu_core_model_inst.gap = 3;
      wr(ra(2, R_ADDR), 32'h2200);
      wr(ra(2, R_COUNT), 32'h3);
      wr(ra(2, R_CTRL), bv(C_EN_ADDR) | bv(C_EN_CNT) | bv(C_ACT_BRK));
      ev(acc(32'h2200), '0, 4'b0000);
      ev(acc(32'h2200), '0, 4'b0000);
      rdc(ra(2, R_STAT), 32'h2);
      ev(acc(32'h2200), '0, 4'b1000);
      ev(acc(32'h2200), '0, 4'b0000);
      wr(ra(2, R_CTRL), 32'h0);
      ecu_core_model_inst.gap = 0;
      $display("test count done");
   endtask : test_count

   task automatic test_win_bus;
      cpu_obs_t c;
      wr(ra(5, R_ADDR), 32'h2000);
      wr(ra(5, R_ADDR_HI), 32'h20FF);
      wr(ra(5, R_CTRL), bv(C_EN_WIN) | bv(C_ACT_TRC));
      ev(acc(32'h2080), '0, 4'b0100);
      ev(acc(32'h2100), '0, 4'b0000);
      ev(acc(32'h1FFF), '0, 4'b0000);
      wr(ra(5, R_CTRL), 32'h0);
      wr(ra(6, R_ADDR), 32'h400);
      wr(ra(6, R_DATA), 32'hFFFF_FFFF);
      wr(ra(6, R_CTRL), bv(C_EN_BUS) | bv(C_BUS_Y) | bv(C_RW_EN) | bv(C_RW_DIR) | bv(C_ACT_BRK));
      c = acc(32'h9000);
      c.xy_valid = 1'b1;
      c.y_sel = 1'b1;
      c.xy_addr = 32'h400;
      c.write = 1'b1;
      ev(c, '0, 4'b1000);
      c.write = 1'b0;
      ev(c, '0, 4'b0000);
      c.write = 1'b1;
      c.xy_addr = 32'h404;
      ev(c, '0, 4'b0000);
      wr(ra(6, R_CTRL), 32'h0);
      $display("test win_bus done");
   endtask : test_win_bus

   task automatic test_tlb_sys_branch;
      cpu_obs_t c;
      wr(ra(7, R_CTRL), bv(C_EN_TLB));
      c = acc(32'h60);
      ev(c, '0, 4'b0000);
      c.tlb_load_instruction = 1'b1;
      ev(c, '0, 4'b1000);
      wr(ra(8, R_ADDR), 32'h3000);
      wr(ra(8, R_DATA), 32'h0BAD_F00D);
      wr(ra(8, R_CTRL), bv(C_EN_SYS) | bv(C_ACT_PST));
      ev('0, '{1'b1, 32'h3000, 32'h0BAD_F00D}, 4'b0010);
      ev('0, '{1'b1, 32'h3004, 32'h1}, 4'b0000);
      wr(ra(12, R_CTRL), bv(C_EN_BR) | bv(C_ACT_PSP));
      c = acc(32'h70);
      ev(c, '0, 4'b0000);
      c.branch = 1'b1;
      ev(c, '0, 4'b0001);
      $display("test tlb_sys_branch done");
   endtask : test_tlb_sys_branch

   task automatic test_sw_seq;
      wr(R_SWTRACE, 32'h1);
      #1 chk({31'h0, sw_trace_en}, 32'h1);
      ev(acc(32'h7770), '0, 4'b0100);
      wr(R_SWTRACE, 32'h0);
      ev(acc(32'h7770), '0, 4'b0000);
      wr(ra(1, R_ADDR), 32'hA00);
      wr(ra(1, R_CTRL), bv(C_EN_ADDR) | bv(C_ACT_BRK));
      wr(ra(2, R_ADDR), 32'hB00);
      wr(ra(2, R_CTRL), bv(C_EN_ADDR) | bv(C_ACT_BRK));
      wr(R_SEQ, 32'h1);
      ev(acc(32'hA00), '0, 4'b0000);
      ev(acc(32'hB00), '0, 4'b0000);
      rdc(R_SEQ, 32'h3);
      ev(acc(32'hA00), '0, 4'b1000);
      rdc(R_SEQ, 32'h1);
      ev(acc(32'hA00), '0, 4'b0000);
      wr(R_HITS, 32'hFFF);
      rdc(R_HITS, 32'h0);
      ev(acc(32'hB00), '0, 4'b0000);
      rdc(R_HITS, 32'h2);
      $display("test sw_seq done");
   endtask : test_sw_seq

   // ********************
   // Run control
   // ********************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   // Main sequence after four reset cycles
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      test_reset_caps();
      test_addr_data();
      test_count();
      test_win_bus();
      test_tlb_sys_branch();
      test_sw_seq();
      end_sim();
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      $display("BAD %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : event_condition_break_unit_tb
